//--- src/pmcas_top.sv
`timescale 1ns/1ns
module pmcas_top #(
    parameter int WINDOWS = 32,
    parameter int LINE_WORDS = 8
) (
    input wire logic CLK_I,
    input wire logic SRST_I,
    input wire logic PCI_RST_I,
    // Register port
    input wire logic [11:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [31:0] RDATA_O,
    // Bus master enable from command/status
    input wire logic BUS_MASTER_ENABLE_I,
    // Pending transactions
    input wire logic CFG_PENDING_I,
    input wire logic IO_PENDING_I,
    input wire logic MEM_PENDING_I,
    output logic CFG_FLUSH_O,
    output logic IO_FLUSH_O,
    output logic MEM_FLUSH_O,
    // Command generation request
    input wire logic REQ_I,
    input wire logic REQ_WRITE_I,
    input wire logic [7:0] REQ_LEN_I,
    input wire logic [31:0] REQ_ADDR_I,
    output logic CMD_VALID_O,
    output logic [3:0] CMD_O,
    output logic [31:0] PCI_ADDR_O,
    // Header registers
    output logic [31:0] VENDEV_HDR_O,
    output logic [31:0] CLREV_HDR_O,
    output logic [31:0] SUBID_HDR_O,
    output logic [15:0] LATGNT_HDR_O,
    output logic HOST_ACCESS_ALLOW_O
);
    localparam int AW = $clog2(WINDOWS);

    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    if (WINDOWS != 32)
    begin : g_bad_win
        $error("pmcas_top: WINDOWS must be 32");
    end
    if (LINE_WORDS < 2 || LINE_WORDS > 128)
    begin : g_bad_line
        $error("pmcas_top: LINE_WORDS out of range");
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [31:0] vendev_q; // Identity default
    logic [31:0] clrev_q; // Class and revision default
    logic [31:0] subid_q; // Subsystem default
    logic [15:0] latgnt_q; // Latency and grant default
    logic cfg_done_q; // Configuration complete
    logic [2:0] flush_q; // {cfg, io, mem}
    logic [2:0] allow_q; // {rd_mult, rd_line, wr_inv}
    logic [31:0] rdata_d; // Next read word
    logic win_rd_q; // Read of a window is pending
    logic [11:0] off_w; // Window byte offset
    logic in_win; // Address hits a window

    pmcas_win_if #(.AW(AW), .DW(pmcas_pkg::SUBS_W)) win ();

    pmcas_win_mem #(.DEPTH(WINDOWS), .AW(AW), .DW(pmcas_pkg::SUBS_W)) u_mem (
        .CLK_I(CLK_I),
        .SRST_I(SRST_I),
        .port(win.mem)
    );

    // Window offset; only meaningful while in_win is true
    assign off_w = ADDR_I - pmcas_pkg::OFF_WIN_BASE;
    // Unaligned addresses in the window range are ignored, so a
    // stray byte access can never touch a neighbouring window
    assign in_win = (ADDR_I >= pmcas_pkg::OFF_WIN_BASE) &&
                    (ADDR_I <= pmcas_pkg::OFF_WIN_LAST) && (ADDR_I[1:0] == 2'h0);
    // Window storage writes and software read index
    assign win.we = WR_I && in_win;
    assign win.waddr = off_w[AW+1:2];
    assign win.wdata = WDATA_I[pmcas_pkg::SUBS_MSB:pmcas_pkg::SUBS_LSB];
    assign win.raddr_a = off_w[AW+1:2];

    // ------------------------------------------------------------
    // Hook registers, writable by software
    // ------------------------------------------------------------
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            vendev_q <= pmcas_pkg::RST_VENDEV;
            clrev_q <= pmcas_pkg::RST_CLREV;
            subid_q <= pmcas_pkg::RST_SUBID;
            latgnt_q <= pmcas_pkg::RST_LATGNT;
        end
        else if (WR_I)
        begin
            // Replaces the reset defaults
            case (ADDR_I)
                pmcas_pkg::OFF_VENDEV: vendev_q <= WDATA_I;
                pmcas_pkg::OFF_CLREV: clrev_q <= WDATA_I;
                pmcas_pkg::OFF_SUBID: subid_q <= WDATA_I;
                pmcas_pkg::OFF_LATGNT: latgnt_q <= WDATA_I[15:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Policy and configuration-complete registers
    // ------------------------------------------------------------
    // Reserved bits of the policy word are dropped on write
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            flush_q <= pmcas_pkg::RST_FLUSH;
            allow_q <= pmcas_pkg::RST_CMD_ALLOW;
            cfg_done_q <= 1'b0;
        end
        else if (WR_I)
        begin
            if (ADDR_I == pmcas_pkg::OFF_MSTCMD)
            begin
                flush_q <= {WDATA_I[pmcas_pkg::BIT_CFG_FLUSH],
                            WDATA_I[pmcas_pkg::BIT_IO_FLUSH],
                            WDATA_I[pmcas_pkg::BIT_MEM_FLUSH]};
                allow_q <= {WDATA_I[pmcas_pkg::BIT_RD_MULT],
                            WDATA_I[pmcas_pkg::BIT_RD_LINE],
                            WDATA_I[pmcas_pkg::BIT_WR_INV]};
            end
            if (ADDR_I == pmcas_pkg::OFF_CFGDONE)
            begin
                cfg_done_q <= WDATA_I[pmcas_pkg::BIT_CFG_DONE];
            end
        end
    end

    // ------------------------------------------------------------
    // Read mux; window reads come from registered memory port
    // ------------------------------------------------------------
    always_comb
    begin
        rdata_d = 32'h0000_0000;
        case (ADDR_I)
            pmcas_pkg::OFF_VENDEV: rdata_d = vendev_q;
            pmcas_pkg::OFF_CLREV: rdata_d = clrev_q;
            pmcas_pkg::OFF_SUBID: rdata_d = subid_q;
            pmcas_pkg::OFF_LATGNT: rdata_d = {16'h0000, latgnt_q};
            pmcas_pkg::OFF_CFGDONE: rdata_d = {31'h0, cfg_done_q};
            pmcas_pkg::OFF_MSTCMD:
                rdata_d = {21'h0, flush_q, 5'h00, allow_q};
            default: rdata_d = 32'h0000_0000; // Unmapped reads zero
        endcase
    end

    // ------------------------------------------------------------
    // Read data return
    // ------------------------------------------------------------
    // Window read flag aligns with memory output
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            win_rd_q <= 1'b0;
        end
        else
        begin
            win_rd_q <= RD_I && in_win;
        end
    end

    // Non-window read data register
    logic [31:0] rdata_q; // Registered plain read word
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            rdata_q <= RD_I ? rdata_d : 32'h0000_0000;
        end
    end

    // Read word is a mux of two registers: the plain read word and
    // the registered window port. Both settle in the cycle after the
    // strobe, so no extra cycle is spent; the flag picks the source
    // and the low 23 bits of a window word always read as zero
    always_comb
    begin
        RDATA_O = win_rd_q ? {win.rdata_a, 23'h000000} : rdata_q;
    end

    // ------------------------------------------------------------
    // Flush control while not bus master
    // ------------------------------------------------------------
    // Flush is a level that stands while its cause stands; the owner
    // of the pending work drops its pending flag in reply
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            CFG_FLUSH_O <= 1'b0;
            IO_FLUSH_O <= 1'b0;
            MEM_FLUSH_O <= 1'b0;
        end
        else
        begin
            CFG_FLUSH_O <= !BUS_MASTER_ENABLE_I && flush_q[2] && CFG_PENDING_I;
            IO_FLUSH_O <= !BUS_MASTER_ENABLE_I && flush_q[1] && IO_PENDING_I;
            MEM_FLUSH_O <= !BUS_MASTER_ENABLE_I && flush_q[0] && MEM_PENDING_I;
        end
    end

    // ------------------------------------------------------------
    // Command generation and address translation
    // ------------------------------------------------------------
    logic req_q; // Request accepted, awaiting window read
    logic req_wr_q; // Held direction
    logic [7:0] req_len_q; // Held burst length
    logic [22:0] req_low_q; // Low address bits pass through
    logic [3:0] cmd_d; // Chosen command
    logic long_burst; // Burst reaches a full line

    // Window index from bits just below the region base
    assign win.raddr_b = REQ_ADDR_I[27:23];

    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            req_q <= 1'b0;
            req_wr_q <= 1'b0;
            req_len_q <= 8'h00;
            req_low_q <= 23'h000000;
        end
        else
        begin
            req_q <= REQ_I && BUS_MASTER_ENABLE_I;
            req_wr_q <= REQ_WRITE_I;
            req_len_q <= REQ_LEN_I;
            req_low_q <= REQ_ADDR_I[22:0];
        end
    end

    // Length counts words; only a burst of a full line or more may
    // use the multiple-read and invalidating-write commands
    assign long_burst = req_len_q >= 8'(LINE_WORDS);

    // Pick the strongest permitted command for the burst
    // Read Line also serves long reads when Read Multiple is barred
    always_comb
    begin
        cmd_d = req_wr_q ? pmcas_pkg::CMD_MEM_WR : pmcas_pkg::CMD_MEM_RD;
        if (req_wr_q)
        begin
            if (long_burst && allow_q[0])
            begin
                cmd_d = pmcas_pkg::CMD_WR_INV;
            end
        end
        else if (long_burst && allow_q[2])
        begin
            cmd_d = pmcas_pkg::CMD_RD_MULT;
        end
        else if (!long_burst && req_len_q > 8'h01 && allow_q[1])
        begin
            cmd_d = pmcas_pkg::CMD_RD_LINE;
        end
        else if (long_burst && allow_q[1])
        begin
            cmd_d = pmcas_pkg::CMD_RD_LINE;
        end
    end

    // Issue command with substituted upper address bits
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            CMD_VALID_O <= 1'b0;
            CMD_O <= 4'h0;
            PCI_ADDR_O <= 32'h0000_0000;
        end
        else
        begin
            CMD_VALID_O <= req_q;
            CMD_O <= req_q ? cmd_d : 4'h0;
            PCI_ADDR_O <= req_q ? {win.rdata_b, req_low_q} : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Header registers latched on PCI reset
    // ------------------------------------------------------------
    // Header follows the hooks, one cycle behind, while PCI reset stands, so a
    // hook write then reaches the header unless it comes in the last cycle of that reset
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I || PCI_RST_I)
        begin
            VENDEV_HDR_O <= vendev_q;
            CLREV_HDR_O <= clrev_q;
            SUBID_HDR_O <= subid_q;
            LATGNT_HDR_O <= latgnt_q;
        end
    end

    // ------------------------------------------------------------
    // Host access gate
    // ------------------------------------------------------------
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            HOST_ACCESS_ALLOW_O <= 1'b0;
        end
        else
        begin
            HOST_ACCESS_ALLOW_O <= cfg_done_q;
        end
    end
endmodule : pmcas_top

//--- common/pmcas_pkg.sv
package pmcas_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] OFF_VENDEV = 12'h394; // Identity default
    localparam logic [11:0] OFF_CLREV = 12'h39c; // Class and revision default
    localparam logic [11:0] OFF_SUBID = 12'h3a0; // Subsystem identity default
    localparam logic [11:0] OFF_LATGNT = 12'h3a4; // Latency and grant default
    localparam logic [11:0] OFF_CFGDONE = 12'h3ac; // Configuration complete
    localparam logic [11:0] OFF_MSTCMD = 12'h3b0; // Master command policy
    localparam logic [11:0] OFF_WIN_BASE = 12'h300; // First window register
    localparam logic [11:0] OFF_WIN_LAST = 12'h37c; // Last window register

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_CFG_FLUSH = 10;
    localparam int BIT_IO_FLUSH = 9;
    localparam int BIT_MEM_FLUSH = 8;
    localparam int BIT_RD_MULT = 2;
    localparam int BIT_RD_LINE = 1;
    localparam int BIT_WR_INV = 0;
    localparam int BIT_CFG_DONE = 0;
    localparam int SUBS_MSB = 31;
    localparam int SUBS_LSB = 23;
    localparam int SUBS_W = 9;
    localparam int LATGNT_W = 16;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    // Identity value is arbitrary, not a real maker code
    localparam logic [31:0] RST_VENDEV = 32'h0001_0001;
    localparam logic [31:0] RST_CLREV = 32'h1180_0001;
    localparam logic [31:0] RST_SUBID = 32'h0000_0000;
    localparam logic [15:0] RST_LATGNT = 16'h0000;
    localparam logic [2:0] RST_CMD_ALLOW = 3'h7;
    localparam logic [2:0] RST_FLUSH = 3'h0;

    // ------------------------------------------------------------
    // Command encodings on the PCI bus
    // ------------------------------------------------------------
    localparam logic [3:0] CMD_MEM_RD = 4'h6;
    localparam logic [3:0] CMD_MEM_WR = 4'h7;
    localparam logic [3:0] CMD_RD_MULT = 4'hc;
    localparam logic [3:0] CMD_RD_LINE = 4'he;
    localparam logic [3:0] CMD_WR_INV = 4'hf;

endpackage : pmcas_pkg

//--- common/pmcas_win_if.sv
`timescale 1ns/1ns
// Window memory port between the top and its storage
interface pmcas_win_if #(parameter int AW = 5, parameter int DW = 9);
    logic we; // Write strobe
    logic [AW-1:0] waddr; // Write index
    logic [DW-1:0] wdata; // Write value
    logic [AW-1:0] raddr_a; // Software read index
    logic [DW-1:0] rdata_a; // Software read value, registered
    logic [AW-1:0] raddr_b; // Translation read index
    logic [DW-1:0] rdata_b; // Translation read value, registered
    modport ctl (output we, waddr, wdata, raddr_a, raddr_b, input rdata_a, rdata_b);
    modport mem (input we, waddr, wdata, raddr_a, raddr_b, output rdata_a, rdata_b);
endinterface : pmcas_win_if

//--- src/pmcas_win_mem.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// Substitution window storage, two registered read ports
// ------------------------------------------------------------
module pmcas_win_mem #(
    parameter int DEPTH = 32,
    parameter int AW = 5,
    parameter int DW = 9
) (
    input wire logic CLK_I,
    input wire logic SRST_I,
    pmcas_win_if.mem port
);
    logic [DW-1:0] mem_q [DEPTH]; // Window fields

    // Index width must reach every entry
    if (DEPTH > (2 ** AW))
    begin : g_bad_depth
        $error("pmcas_win_mem: DEPTH exceeds index range");
    end

    // Writes and clear to zero on reset
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                mem_q[i] <= '0;
            end
        end
        else if (port.we)
        begin
            mem_q[port.waddr] <= port.wdata;
        end
    end

    // Registered reads for both ports
    always_ff @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            port.rdata_a <= '0;
            port.rdata_b <= '0;
        end
        else
        begin
            port.rdata_a <= mem_q[port.raddr_a];
            port.rdata_b <= mem_q[port.raddr_b];
        end
    end
endmodule : pmcas_win_mem

//--- dv/pmcas_monitor.sv
`timescale 1ns/1ns
// --------
// Port checker
// --------
module pmcas_monitor #(
    parameter int LINE_WORDS = 8
) (
    input wire logic CLK_I,
    input wire logic SRST_I,
    input wire logic PCI_RST_I,
    input wire logic [11:0] ADDR_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [31:0] RDATA_O,
    input wire logic BUS_MASTER_ENABLE_I,
    input wire logic CFG_PENDING_I,
    input wire logic IO_PENDING_I,
    input wire logic MEM_PENDING_I,
    input wire logic CFG_FLUSH_O,
    input wire logic IO_FLUSH_O,
    input wire logic MEM_FLUSH_O,
    input wire logic REQ_I,
    input wire logic REQ_WRITE_I,
    input wire logic [7:0] REQ_LEN_I,
    input wire logic [31:0] REQ_ADDR_I,
    input wire logic CMD_VALID_O,
    input wire logic [3:0] CMD_O,
    input wire logic [31:0] PCI_ADDR_O,
    input wire logic [31:0] VENDEV_HDR_O,
    input wire logic HOST_ACCESS_ALLOW_O
);
    logic [22:0] low_addr; // Untranslated part of the request
    assign low_addr = REQ_ADDR_I[22:0];
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SRST_I);
    // Flushes only ever follow a disabled master with work pending
    AST_CFG_FLUSH:
    assert property (CFG_FLUSH_O |-> $past(!BUS_MASTER_ENABLE_I && CFG_PENDING_I))
        else $error("config flush without cause");
    AST_IO_FLUSH:
    assert property (IO_FLUSH_O |-> $past(!BUS_MASTER_ENABLE_I && IO_PENDING_I))
        else $error("io flush without cause");
    AST_MEM_FLUSH:
    assert property (MEM_FLUSH_O |-> $past(!BUS_MASTER_ENABLE_I && MEM_PENDING_I))
        else $error("memory flush without cause");
    // Command answer is exactly two cycles after an accepted request
    AST_CMD_LAT:
    assert property (REQ_I && BUS_MASTER_ENABLE_I |-> ##2 CMD_VALID_O)
        else $error("command missing");
    AST_MULT:
    assert property (CMD_VALID_O && CMD_O == pmcas_pkg::CMD_RD_MULT
        |-> !$past(REQ_WRITE_I, 2) && $past(REQ_LEN_I, 2) >= LINE_WORDS)
        else $error("bad read multiple");
    AST_LINE:
    assert property (CMD_VALID_O && CMD_O == pmcas_pkg::CMD_RD_LINE
        |-> !$past(REQ_WRITE_I, 2) && $past(REQ_LEN_I, 2) > 8'h1)
        else $error("bad read line");
    AST_WINV:
    assert property (CMD_VALID_O && CMD_O == pmcas_pkg::CMD_WR_INV
        |-> $past(REQ_WRITE_I, 2) && $past(REQ_LEN_I, 2) >= LINE_WORDS)
        else $error("bad write invalidate");
    AST_LOW_ADDR:
    assert property (CMD_VALID_O |-> PCI_ADDR_O[22:0] == $past(low_addr, 2))
        else $error("low address altered");
    AST_ALLOW:
    assert property ($rose(HOST_ACCESS_ALLOW_O)
        |-> $past(WR_I, 2) && $past(ADDR_I, 2) == pmcas_pkg::OFF_CFGDONE)
        else $error("host access opened without write");
    AST_HDR:
    assert property ($changed(VENDEV_HDR_O) |-> $past(PCI_RST_I) || $past(SRST_I))
        else $error("header moved outside reset");
    AST_RD_IDLE:
    assert property (RDATA_O != 32'h0 |-> $past(RD_I))
        else $error("read data outside read slot");
endmodule : pmcas_monitor

bind pmcas_top pmcas_monitor #(.LINE_WORDS(LINE_WORDS)) pmcas_monitor_i (
    .CLK_I(CLK_I), .SRST_I(SRST_I), .PCI_RST_I(PCI_RST_I), .ADDR_I(ADDR_I),
    .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .BUS_MASTER_ENABLE_I(BUS_MASTER_ENABLE_I),
    .CFG_PENDING_I(CFG_PENDING_I), .IO_PENDING_I(IO_PENDING_I),
    .MEM_PENDING_I(MEM_PENDING_I), .CFG_FLUSH_O(CFG_FLUSH_O), .IO_FLUSH_O(IO_FLUSH_O),
    .MEM_FLUSH_O(MEM_FLUSH_O), .REQ_I(REQ_I), .REQ_WRITE_I(REQ_WRITE_I),
    .REQ_LEN_I(REQ_LEN_I), .REQ_ADDR_I(REQ_ADDR_I), .CMD_VALID_O(CMD_VALID_O),
    .CMD_O(CMD_O), .PCI_ADDR_O(PCI_ADDR_O), .VENDEV_HDR_O(VENDEV_HDR_O),
    .HOST_ACCESS_ALLOW_O(HOST_ACCESS_ALLOW_O));

//--- dv/pmcas_pci_tgt.sv
`timescale 1ns/1ns
// --------
// Far-side target: records each command put on the bus
// --------
module pmcas_pci_tgt (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic valid_i,
    input wire logic [3:0] cmd_i,
    input wire logic [31:0] addr_i,
    output logic [3:0] cmd_o,
    output logic [31:0] addr_o,
    output logic [7:0] seen_o
);
    // Count lets the bench see a command it might otherwise miss
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            seen_o <= 8'h0;
        else if (valid_i)
        begin
            cmd_o <= cmd_i;
            addr_o <= addr_i;
            seen_o <= seen_o + 8'h1;
        end
    end
endmodule : pmcas_pci_tgt

//--- dv/tb.sv
`timescale 1ns/1ns
module tb;
    // --------
    // Stimulus and observed ports
    // --------
    logic CLK_I = 1'b0, SRST_I = 1'b1, PCI_RST_I = 1'b0, WR_I = 1'b0, RD_I = 1'b0;
    logic BUS_MASTER_ENABLE_I = 1'b1, REQ_I = 1'b0, REQ_WRITE_I = 1'b0;
    logic CFG_PENDING_I = 1'b0, IO_PENDING_I = 1'b0, MEM_PENDING_I = 1'b0;
    logic [11:0] ADDR_I = 12'h0;
    logic [31:0] WDATA_I = 32'h0, REQ_ADDR_I = 32'h0;
    logic [7:0] REQ_LEN_I = 8'h0, seen;
    logic [31:0] RDATA_O, PCI_ADDR_O, VENDEV_HDR_O, CLREV_HDR_O, SUBID_HDR_O, t_addr;
    logic [15:0] LATGNT_HDR_O;
    logic [3:0] CMD_O, t_cmd;
    logic CFG_FLUSH_O, IO_FLUSH_O, MEM_FLUSH_O, CMD_VALID_O, HOST_ACCESS_ALLOW_O, ok;
    int mismatches = 0;
    int checks_done = 0;
    typedef struct {logic w; logic [7:0] n; logic [2:0] al; logic [3:0] c;} pmcas_row_t;
    // Request kind, length, allow bits, expected command
    pmcas_row_t rows[8] = '{'{1'b0, 8'h8, 3'h7, 4'hc}, '{1'b0, 8'h8, 3'h3, 4'he},
        '{1'b0, 8'h2, 3'h5, 4'h6}, '{1'b0, 8'h1, 3'h7, 4'h6}, '{1'b0, 8'h7, 3'h7, 4'he},
        '{1'b1, 8'h8, 3'h7, 4'hf}, '{1'b1, 8'h8, 3'h6, 4'h7}, '{1'b1, 8'h7, 3'h7, 4'h7}};
    pmcas_top #(.WINDOWS(32), .LINE_WORDS(8)) pmcas_top_i (.CLK_I(CLK_I), .SRST_I(SRST_I),
        .PCI_RST_I(PCI_RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
        .RDATA_O(RDATA_O), .BUS_MASTER_ENABLE_I(BUS_MASTER_ENABLE_I),
        .CFG_PENDING_I(CFG_PENDING_I), .IO_PENDING_I(IO_PENDING_I),
        .MEM_PENDING_I(MEM_PENDING_I), .CFG_FLUSH_O(CFG_FLUSH_O), .IO_FLUSH_O(IO_FLUSH_O),
        .MEM_FLUSH_O(MEM_FLUSH_O), .REQ_I(REQ_I), .REQ_WRITE_I(REQ_WRITE_I),
        .REQ_LEN_I(REQ_LEN_I), .REQ_ADDR_I(REQ_ADDR_I), .CMD_VALID_O(CMD_VALID_O),
        .CMD_O(CMD_O), .PCI_ADDR_O(PCI_ADDR_O), .VENDEV_HDR_O(VENDEV_HDR_O),
        .CLREV_HDR_O(CLREV_HDR_O), .SUBID_HDR_O(SUBID_HDR_O), .LATGNT_HDR_O(LATGNT_HDR_O),
        .HOST_ACCESS_ALLOW_O(HOST_ACCESS_ALLOW_O));
    pmcas_pci_tgt pmcas_pci_tgt_i (.clk_i(CLK_I), .rst_i(SRST_I), .valid_i(CMD_VALID_O),
        .cmd_i(CMD_O), .addr_i(PCI_ADDR_O), .cmd_o(t_cmd), .addr_o(t_addr), .seen_o(seen));
    // 25 MHz clock
    initial
    begin
        forever #20 CLK_I = ~CLK_I;
    end
    // --------
    // Bus and compare tasks
    // --------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge CLK_I);
        ADDR_I <= a;
        WDATA_I <= d;
        WR_I <= 1'b1;
        @(posedge CLK_I);
        WR_I <= 1'b0;
    endtask : wr
    // Data stands only in the cycle after the strobe
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge CLK_I);
        ADDR_I <= a;
        RD_I <= 1'b1;
        @(posedge CLK_I);
        RD_I <= 1'b0;
        #1;
        chk(RDATA_O, e);
    endtask : rd
    // Answer is fixed at two cycles; the wait covers that plus capture
    task automatic req(input logic w, input logic [7:0] n, input logic [31:0] a);
        logic [7:0] n0;
        n0 = seen;
        @(posedge CLK_I);
        REQ_I <= 1'b1;
        REQ_WRITE_I <= w;
        REQ_LEN_I <= n;
        REQ_ADDR_I <= a;
        @(posedge CLK_I);
        REQ_I <= 1'b0;
        repeat (3) @(posedge CLK_I);
        #1;
        ok = (seen != n0);
    endtask : req
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    // --------
    // Main sequence
    // --------
    initial
    begin
        repeat (5) @(posedge CLK_I);
        SRST_I <= 1'b0;
        rd(pmcas_pkg::OFF_MSTCMD, 32'h7);
        rd(pmcas_pkg::OFF_CLREV, 32'h1180_0001);
        rd(pmcas_pkg::OFF_VENDEV, pmcas_pkg::RST_VENDEV);
        rd(12'h010, 32'h0);
        chk(CLREV_HDR_O, 32'h1180_0001);
        chk(SUBID_HDR_O, pmcas_pkg::RST_SUBID);
        chk({31'h0, HOST_ACCESS_ALLOW_O}, 32'h0);
        $display("reset values done");
        wr(12'h314, 32'hd5ff_ffff);
        wr(pmcas_pkg::OFF_WIN_LAST, 32'hffff_ffff);
        rd(12'h314, 32'hd580_0000);
        rd(pmcas_pkg::OFF_WIN_LAST, 32'hff80_0000);
        rd(pmcas_pkg::OFF_WIN_BASE, 32'h0);
        for (int i = 0; i < 8; i++)
        begin
            wr(pmcas_pkg::OFF_MSTCMD, {29'h0, rows[i].al});
            req(rows[i].w, rows[i].n, 32'h02ab_cdef);
            chk({31'h0, ok}, 32'h1);
            if (!ok)
                report_and_stop();
            chk({28'h0, t_cmd}, {28'h0, rows[i].c});
            chk(t_addr, {9'h1ab, 23'h2b_cdef});
        end
        req(1'b0, 8'h1, 32'h0f81_2345);
        chk(t_addr, {9'h1ff, 23'h01_2345});
        $display("command rows done");
        @(posedge CLK_I);
        BUS_MASTER_ENABLE_I <= 1'b0;
        CFG_PENDING_I <= 1'b1;
        IO_PENDING_I <= 1'b1;
        MEM_PENDING_I <= 1'b1;
        req(1'b0, 8'h8, 32'h0);
        chk({31'h0, ok}, 32'h0);
        for (int b = 0; b < 4; b++)
        begin
            wr(pmcas_pkg::OFF_MSTCMD, 32'h7 | ((b < 3) ? (32'h100 << b) : 32'h0));
            repeat (2) @(posedge CLK_I);
            #1;
            chk({29'h0, CFG_FLUSH_O, IO_FLUSH_O, MEM_FLUSH_O}, 32'h7 & (32'h1 << b));
        end
        wr(pmcas_pkg::OFF_MSTCMD, 32'h707);
        BUS_MASTER_ENABLE_I <= 1'b1;
        repeat (2) @(posedge CLK_I);
        #1;
        chk({29'h0, CFG_FLUSH_O, IO_FLUSH_O, MEM_FLUSH_O}, 32'h0);
        $display("flush done");
        wr(pmcas_pkg::OFF_VENDEV, 32'h5a5a_0f0f);
        wr(pmcas_pkg::OFF_SUBID, 32'h1234_5678);
        wr(pmcas_pkg::OFF_LATGNT, 32'hffff_ffff);
        rd(pmcas_pkg::OFF_LATGNT, 32'h0000_ffff);
        chk(VENDEV_HDR_O, pmcas_pkg::RST_VENDEV);
        @(posedge CLK_I);
        PCI_RST_I <= 1'b1;
        @(posedge CLK_I);
        PCI_RST_I <= 1'b0;
        repeat (2) @(posedge CLK_I);
        #1;
        chk(VENDEV_HDR_O, 32'h5a5a_0f0f);
        chk({16'h0, LATGNT_HDR_O}, 32'h0000_ffff);
        chk(SUBID_HDR_O, 32'h1234_5678);
        wr(pmcas_pkg::OFF_CFGDONE, 32'hffff_ffff);
        rd(pmcas_pkg::OFF_CFGDONE, 32'h1);
        chk({31'h0, HOST_ACCESS_ALLOW_O}, 32'h1);
        $display("hooks done");
        @(posedge CLK_I);
        SRST_I <= 1'b1;
        repeat (2) @(posedge CLK_I);
        SRST_I <= 1'b0;
        rd(pmcas_pkg::OFF_MSTCMD, 32'h7);
        chk(VENDEV_HDR_O, pmcas_pkg::RST_VENDEV);
        $display("second reset done");
        report_and_stop();
    end
endmodule : tb
